/* File: rtl/sadc_regs.svh */
// constants for the serial converter frame and power control
`ifndef SADC_REGS_SVH
`define SADC_REGS_SVH

`define SADC_CODE_W 8
`define SADC_WORD_W 16
`define SADC_LEAD_ZEROS 3
`define SADC_TRAIL_ZEROS 5
`define SADC_CNT_W 5
`define SADC_CNT_MAX 5'h1F
`define SADC_GLITCH_FALLS 5'h02
`define SADC_SHUT_FALLS 5'h0A
`define SADC_FRAME_FALLS 5'h10
`define SADC_TRACK_RISE 5'h0D
`define SADC_FIFO_DEPTH 8

`endif

/* File: rtl/sadc_pkg.sv */
// types for the serial converter frame and power control
package sadc_pkg;
  typedef enum logic {
    SADC_NORMAL,
    SADC_SHUTDOWN
  } sadc_mode_t;

  typedef logic [7:0] sadc_code_t;
endpackage

/* File: rtl/sadc_sync.sv */
// two-flop synchroniser with edge pulses for one pin
`timescale 1ns/1ps
module sadc_sync (
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  input wire logic pin_i,
  input wire logic rst_level_i,
  output logic level_o,
  output logic fall_o,
  output logic rise_o
);
  logic meta_ff;
  logic sync_ff;
  logic prev_ff;

  always_ff @(posedge ref_clk_i) begin
    meta_ff <= pin_i;
    sync_ff <= meta_ff;
    if (sys_rst_i) begin
      prev_ff <= 1'b1;
    end else begin
      prev_ff <= sync_ff;
    end
  end

  assign level_o = sync_ff;
  assign fall_o = prev_ff & ~sync_ff & ~sys_rst_i & ~rst_level_i;
  assign rise_o = ~prev_ff & sync_ff & ~sys_rst_i;
endmodule

/* File: rtl/sadc_fifo.sv */
// sample buffer with valid and ready on both sides, registered read data
`timescale 1ns/1ps
module sadc_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  input wire logic [WIDTH-1:0] in_data_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  output logic [WIDTH-1:0] out_data_o,
  output logic out_valid_o,
  input wire logic out_ready_i
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW-1:0] wr_ptr_ff;
  logic [AW-1:0] rd_ptr_ff;
  logic [AW:0] count_ff;
  logic [WIDTH-1:0] rd_data_ff;
  logic ready_ff;
  logic valid_ff;
  logic push;
  logic pop;
  logic load;
  logic [AW:0] nxt_count;
  logic nxt_valid;
  logic [AW:0] nxt_fill;

  // the head word sits in rd_data_ff; memory holds the rest
  assign push = in_valid_i & ready_ff;
  assign pop = valid_ff & out_ready_i;
  assign load = (count_ff != '0) & (~valid_ff | pop);
  assign nxt_count = count_ff + (AW+1)'(push) - (AW+1)'(load);
  assign nxt_valid = load | (valid_ff & ~pop);
  // the head word counts toward the depth, so at most DEPTH words are held
  assign nxt_fill = nxt_count + (AW+1)'(nxt_valid);

  always_ff @(posedge ref_clk_i) begin
    if (push) begin
      mem_ff[wr_ptr_ff] <= in_data_i;
    end
    if (load) begin
      rd_data_ff <= mem_ff[rd_ptr_ff];
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      count_ff <= '0;
      valid_ff <= 1'b0;
      ready_ff <= 1'b0;
    end else begin
      wr_ptr_ff <= push ? AW'(wr_ptr_ff + 1'b1) : wr_ptr_ff;
      rd_ptr_ff <= load ? AW'(rd_ptr_ff + 1'b1) : rd_ptr_ff;
      count_ff <= nxt_count;
      valid_ff <= nxt_valid;
      ready_ff <= nxt_fill < (AW+1)'(DEPTH);
    end
  end

  assign in_ready_o = ready_ff;
  assign out_data_o = rd_data_ff;
  assign out_valid_o = valid_ff;
endmodule

/* File: rtl/sadc_ctrl.sv */
// frame sequencing, power mode and serial output of the 8-bit converter
//
// Overview of operation
// - chip select fall enters normal, starts conversion
// - rise after 2nd, by 10th fall: shutdown
// - rise before 2nd fall keeps mode; code enters shutdown if unpowered
// - rise after 11th, before 16th: abort, stay normal
// - shutdown lasts until next chip select fall
// - wake frame ended by 10th fall: shutdown
// - full power after 16 clocks of wake
// - first conversion after wake is invalid
// - output released after sixteen serial clocks
// - result is straight binary code
// - three zeros, eight bits msb first, zeros
// - hold on select fall, track at 13th rise
// - release at 16th fall or select rise
`timescale 1ns/1ps
`include "sadc_regs.svh"
module sadc_ctrl #(
  parameter int CODE_W = `SADC_CODE_W,
  parameter int FIFO_DEPTH = `SADC_FIFO_DEPTH
) (
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  input wire logic cs_n_i,
  input wire logic sclk_i,
  input wire sadc_pkg::sadc_code_t sample_i,
  input wire logic sample_valid_i,
  output logic sample_ready_o,
  output logic serial_result_out_o,
  output logic serial_result_oe_o,
  output logic shutdown_o,
  output logic powered_o,
  output logic track_o,
  output logic result_valid_o
);
  import sadc_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers and sample buffer

  logic cs_lvl;
  logic cs_fall;
  logic cs_rise;
  logic sclk_fall;
  logic sclk_rise;
  sadc_code_t buf_data;
  logic buf_valid;

  sadc_sync u_cs_sync (
    .ref_clk_i(ref_clk_i),
    .sys_rst_i(sys_rst_i),
    .pin_i(cs_n_i),
    .rst_level_i(1'b0),
    .level_o(cs_lvl),
    .fall_o(cs_fall),
    .rise_o(cs_rise)
  );

  sadc_sync u_sclk_sync (
    .ref_clk_i(ref_clk_i),
    .sys_rst_i(sys_rst_i),
    .pin_i(sclk_i),
    .rst_level_i(cs_lvl),
    .level_o(),
    .fall_o(sclk_fall),
    .rise_o(sclk_rise)
  );

  sadc_fifo #(
    .WIDTH(CODE_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .ref_clk_i(ref_clk_i),
    .sys_rst_i(sys_rst_i),
    .in_data_i(sample_i),
    .in_valid_i(sample_valid_i),
    .in_ready_o(sample_ready_o),
    .out_data_o(buf_data),
    .out_valid_o(buf_valid),
    .out_ready_i(cs_fall)
  );

  ////////////////////////////////////////////////////////////////////////////
  // frame state

  sadc_mode_t mode_ff;
  logic active_ff;
  logic wake_ff;
  logic warm_ff;
  logic powered_ff;
  logic track_ff;
  logic oe_ff;
  logic valid_ff;
  logic [`SADC_CNT_W-1:0] fall_cnt_ff;
  logic [`SADC_CNT_W-1:0] rise_cnt_ff;
  logic [`SADC_WORD_W-1:0] shift_ff;

  logic [`SADC_CNT_W-1:0] nxt_fall_cnt;
  logic [`SADC_CNT_W-1:0] nxt_rise_cnt;
  logic end_rise;
  logic early_rise;
  logic shut_rise;
  logic done_fall;
  logic wake_full;
  sadc_code_t conv_code;

  function automatic logic [`SADC_CNT_W-1:0] sat_inc(input logic [`SADC_CNT_W-1:0] v);
    sat_inc = (v == `SADC_CNT_MAX) ? v : `SADC_CNT_W'(v + 1'b1);
  endfunction

  assign nxt_fall_cnt = sat_inc(fall_cnt_ff);
  assign nxt_rise_cnt = sat_inc(rise_cnt_ff);
  assign end_rise = cs_rise & active_ff;
  assign early_rise = end_rise & (fall_cnt_ff < `SADC_GLITCH_FALLS);
  assign shut_rise = end_rise & ~early_rise & (fall_cnt_ff <= `SADC_SHUT_FALLS);
  assign done_fall = active_ff & sclk_fall & (nxt_fall_cnt == `SADC_FRAME_FALLS);
  assign wake_full = done_fall & wake_ff;
  // an empty buffer converts as code zero
  assign conv_code = buf_valid ? buf_data : '0;

  ////////////////////////////////////////////////////////////////////////////
  // mode and power

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      mode_ff <= SADC_NORMAL;
      wake_ff <= 1'b0;
      powered_ff <= 1'b0;
      warm_ff <= 1'b0;
    end else if (cs_fall) begin
      mode_ff <= SADC_NORMAL;
      wake_ff <= (mode_ff == SADC_SHUTDOWN) | ~powered_ff;
    end else if (shut_rise | (early_rise & wake_ff)) begin
      mode_ff <= SADC_SHUTDOWN;
      wake_ff <= 1'b0;
      powered_ff <= 1'b0;
      warm_ff <= 1'b0;
    end else if (wake_full) begin
      wake_ff <= 1'b0;
      powered_ff <= 1'b1;
    end else if (done_fall | (end_rise & ~early_rise)) begin
      warm_ff <= powered_ff | wake_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // edge counting and serial output

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      active_ff <= 1'b0;
      fall_cnt_ff <= '0;
      rise_cnt_ff <= '0;
    end else if (cs_fall) begin
      active_ff <= 1'b1;
      fall_cnt_ff <= '0;
      rise_cnt_ff <= '0;
    end else if (cs_rise) begin
      active_ff <= 1'b0;
      fall_cnt_ff <= '0;
      rise_cnt_ff <= '0;
    end else if (active_ff) begin
      fall_cnt_ff <= sclk_fall ? nxt_fall_cnt : fall_cnt_ff;
      rise_cnt_ff <= sclk_rise ? nxt_rise_cnt : rise_cnt_ff;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      shift_ff <= '0;
      oe_ff <= 1'b0;
      track_ff <= 1'b1;
      valid_ff <= 1'b0;
    end else if (cs_fall) begin
      shift_ff <= {`SADC_LEAD_ZEROS'(0), conv_code, `SADC_TRAIL_ZEROS'(0)};
      oe_ff <= 1'b1;
      track_ff <= 1'b0;
      valid_ff <= warm_ff & (mode_ff == SADC_NORMAL);
    end else if (cs_rise) begin
      oe_ff <= 1'b0;
      track_ff <= 1'b1;
    end else if (active_ff) begin
      if (sclk_fall) begin
        shift_ff <= {shift_ff[`SADC_WORD_W-2:0], 1'b0};
      end
      if (done_fall) begin
        oe_ff <= 1'b0;
      end
      if (sclk_rise & (nxt_rise_cnt == `SADC_TRACK_RISE)) begin
        track_ff <= 1'b1;
      end
    end
  end

  assign serial_result_out_o = shift_ff[`SADC_WORD_W-1];
  assign serial_result_oe_o = oe_ff;
  assign shutdown_o = (mode_ff == SADC_SHUTDOWN);
  assign powered_o = powered_ff;
  assign track_o = track_ff;
  assign result_valid_o = valid_ff;
endmodule

/* File: verification/sadc_ctrl_asserts.sv */
// concurrent checks on the converter control ports
`timescale 1ns/1ps
module sadc_ctrl_asserts (
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  input wire logic cs_n_i,
  input wire logic serial_result_out_o,
  input wire logic serial_result_oe_o,
  input wire logic shutdown_o,
  input wire logic powered_o,
  input wire logic track_o,
  input wire logic result_valid_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (sys_rst_i);
  sequence cs_start;
    $fell(cs_n_i);
  endsequence
  sequence drive_zero;
    serial_result_oe_o && !serial_result_out_o && !track_o;
  endsequence
  frame_start_a: assert property (cs_start |-> ##[3:5] drive_zero)
    else $error("frame start did not drive a zero in hold");
  pin_release_a: assert property (cs_n_i [*6] |-> !serial_result_oe_o)
    else $error("data pin driven with select high");
  oe_cause_a: assert property ($rose(serial_result_oe_o) |-> !cs_n_i)
    else $error("data pin enabled outside a frame");
  shut_cause_a: assert property ($rose(shutdown_o) |-> cs_n_i)
    else $error("shutdown entered with select low");
  shut_wake_a: assert property ($fell(shutdown_o) |-> !cs_n_i)
    else $error("shutdown left without select low");
  shut_quiet_a: assert property (shutdown_o && cs_n_i && $past(cs_n_i, 6) |->
    !serial_result_oe_o)
    else $error("data pin driven in shutdown");
  unpowered_a: assert property (shutdown_o |-> !powered_o)
    else $error("powered flag set in shutdown");
  power_loss_a: assert property ($fell(powered_o) |-> ##[0:1] shutdown_o)
    else $error("power lost without shutdown");
  valid_start_a: assert property ($rose(result_valid_o) |-> !cs_n_i)
    else $error("result valid set outside a frame");
endmodule

/* File: verification/sadc_host_model.sv */
// host model driving select and serial clock, capturing the data pin
`timescale 1ns/1ps
module sadc_host_model (
  input wire logic ref_clk_i,
  input wire logic data_i,
  input wire logic data_oe_i,
  output logic cs_n_o,
  output logic sclk_o
);
  initial begin
    cs_n_o = 1'b1;
    sclk_o = 1'b1;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk_i);
    #1;
  endtask
  // frame of nf clock falls, 160 ref clocks long when nf is 16
  task automatic frame(input int nf, output logic [15:0] w);
    w = 16'h0;
    cs_n_o = 1'b0;
    tick(8);
    for (int k = 1; k <= nf; k++) begin
      w = {w[14:0], data_oe_i ? data_i : 1'bz};
      sclk_o = 1'b0;
      tick(4);
      sclk_o = 1'b1;
      tick(4);
    end
    cs_n_o = 1'b1;
    tick(24);
  endtask
endmodule

/* File: verification/serial_adc_frame_power_control_tb_top.sv */
// self-checking bench for the converter frame and power control
`timescale 1ns/1ps
module serial_adc_frame_power_control_tb_top;
  import sadc_pkg::*;
  logic ref_clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic sample_valid = 1'b0;
  logic cs_n, sclk, ready, sdo, oe, shut, pwr, trk, rvalid;
  sadc_code_t sample = 8'h00;
  logic [15:0] w;
  int n_fail = 0;
  int checks_done = 0;
  always #25 ref_clk_i = ~ref_clk_i;
  sadc_ctrl uut (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .cs_n_i(cs_n), .sclk_i(sclk),
    .sample_i(sample), .sample_valid_i(sample_valid), .sample_ready_o(ready),
    .serial_result_out_o(sdo), .serial_result_oe_o(oe), .shutdown_o(shut),
    .powered_o(pwr), .track_o(trk), .result_valid_o(rvalid));
  sadc_host_model host (.ref_clk_i(ref_clk_i), .data_i(sdo), .data_oe_i(oe),
    .cs_n_o(cs_n), .sclk_o(sclk));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk_i);
    #1;
  endtask
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
      n_fail++;
    end
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic push(input sadc_code_t c);
    int i;
    sample = c;
    sample_valid = 1'b1;
    for (i = 0; i < 20 && ready !== 1'b1; i++) tick(1);
    if (i == 20) begin
      n_fail++;
      close_out();
    end
    tick(1);
    sample_valid = 1'b0;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_power_up;
    host.frame(16, w);
    check(pwr, 1'b1);
    check(oe, 1'b0);
    check(rvalid, 1'b0);
    check(shut, 1'b0);
    $display("test power up done");
  endtask
  task automatic t_buffer;
    for (int k = 0; k < 8; k++) push(8'hFF - 8'h24 * k);
    tick(2);
    check(ready, 1'b0);
    sample = 8'h5A;
    sample_valid = 1'b1;
    tick(3);
    sample_valid = 1'b0;
    for (int k = 0; k < 8; k++) begin
      host.frame(16, w);
      check(w, {3'h0, sadc_code_t'(8'hFF - 8'h24 * k), 5'h00});
      check(rvalid, 1'b1);
    end
    host.frame(16, w);
    check(w, 16'h0000);
    check(ready, 1'b1);
    $display("test buffer done");
  endtask
  task automatic t_abort;
    host.frame(11, w);
    check(shut, 1'b0);
    check(oe, 1'b0);
    host.frame(1, w);
    check(shut, 1'b0);
    check(pwr, 1'b1);
    $display("test abort done");
  endtask
  task automatic t_shutdown;
    host.frame(2, w);
    check(shut, 1'b1);
    check(pwr, 1'b0);
    tick(40);
    check(shut, 1'b1);
    host.frame(4, w);
    check(shut, 1'b1);
    host.frame(10, w);
    check(shut, 1'b1);
    host.frame(16, w);
    check(shut, 1'b0);
    check(pwr, 1'b1);
    check(rvalid, 1'b0);
    push(8'h96);
    host.frame(16, w);
    check(w, {3'h0, 8'h96, 5'h00});
    check(rvalid, 1'b1);
    $display("test shutdown done");
  endtask
  initial begin
    repeat (4) @(posedge ref_clk_i);
    #1;
    sys_rst_i = 1'b0;
    tick(3);
    t_power_up();
    t_buffer();
    t_abort();
    t_shutdown();
    close_out();
  end
endmodule
bind sadc_ctrl sadc_ctrl_asserts chk (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i),
  .cs_n_i(cs_n_i), .serial_result_out_o(serial_result_out_o),
  .serial_result_oe_o(serial_result_oe_o), .shutdown_o(shutdown_o), .powered_o(powered_o),
  .track_o(track_o), .result_valid_o(result_valid_o));
